// [hw/sbcs_core.sv]
// serial port unit: control/status, holding buffers, shifter, bus slave
//
// The register addresses and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
module sbcs_core
  import sbcs_pkg::*;
#(
  parameter int WORD_W = SBCS_WORD_W,
  parameter int DEPTH = SBCS_DEPTH,
  parameter int HALF_DIV = SBCS_HALF_DIV
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  input wire logic serialInPin,
  output logic sdoOut,
  output logic sdoOe,
  input wire logic targetSelectPinN,
  output logic irq,
  output logic selectPinUse,
  output logic serialInUsed
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW-1:0] ONE = PW'(1);
  localparam logic [PW-1:0] HALF = PW'(DEPTH / 2);
  localparam logic [PW-1:0] TOP = PW'(DEPTH - 1);
  localparam logic [15:0] DIV_END = 16'(HALF_DIV - 1);
  localparam logic [3:0] LAST_BIT = 4'(WORD_W - 1);

  logic [31:0] ctrl_reg;
  logic [WORD_W-1:0] txMem [DEPTH];
  logic [WORD_W-1:0] rxMem [DEPTH];
  logic [PW-1:0] txW_reg, txR_reg, rxW_reg, rxR_reg;
  logic tbe_reg, rbf_reg, popArm_reg, txLoaded_reg, txCondPrev, rxCondPrev;
  logic [SBCS_IRQ_W-1:0] irqStat_reg, irqMask_reg, irqSet, irqClr;
  sbcs_state_e state_reg;
  logic [WORD_W-1:0] sr_reg;
  logic [3:0] bitCnt_reg;
  logic [15:0] halfCnt_reg;
  logic inBit_reg;
  logic [2:0] pinRaw, pinLvl, pinRose, pinFell;

  logic on, enh, mst, select_pin_use, dissi, cpolEff;
  logic wrEn, rdEn, swPush, swPop, ctrlWr;
  logic [PW-1:0] txCount, rxCount;
  logic txEmpty, txFull, rxEmpty, rxFull;
  logic selected, start, shPop, shPush, rxDrop, tick, lead, trail, rxBit;
  logic txCond, rxCond, txEvt, rxEvt;
  logic [31:0] rdMux;

  assign pinRaw = {targetSelectPinN, serialInPin, sckIn};
  for (genvar i = 0; i < 3; i++) begin : g_sync
    // select pin idles high
    sbcs_sync #(.RST_LVL(i == 2)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .din(pinRaw[i]),
      .level(pinLvl[i]),
      .rose(pinRose[i]),
      .fell(pinFell[i])
    );
  end

  assign on = ctrl_reg[SBCS_CTRL_ON];
  assign enh = ctrl_reg[SBCS_CTRL_ENH];
  assign mst = ctrl_reg[SBCS_CTRL_MST];
  assign select_pin_use = ctrl_reg[SBCS_CTRL_SELECT_PIN_USE];
  // release bit has no meaning in framed operation
  assign dissi = ctrl_reg[SBCS_CTRL_DISSI] && !ctrl_reg[SBCS_CTRL_FRM];
  assign cpolEff = ctrl_reg[SBCS_CTRL_CKP] | ctrl_reg[SBCS_CTRL_AUD];

  // a request is taken on the edge where waitrequest is already low
  assign wrEn = write && !waitrequest;
  assign rdEn = read && !waitrequest;
  assign ctrlWr = wrEn && address == SBCS_ADDR_CTRL;

  assign txCount = txW_reg - txR_reg;
  assign rxCount = rxW_reg - rxR_reg;
  assign txEmpty = txW_reg == txR_reg;
  assign txFull = enh ? (txW_reg + ONE == txR_reg) : !txEmpty;
  assign rxEmpty = enh ? (rxW_reg == rxR_reg) : !rbf_reg;
  assign rxFull = enh ? (rxW_reg + ONE == rxR_reg) : rbf_reg;

  assign swPush = on && wrEn && address == SBCS_ADDR_BUF && !txFull;
  // pop armed at the latch edge so the word returned is the word removed
  assign swPop = on && rdEn && address == SBCS_ADDR_BUF && popArm_reg;

  assign selected = !select_pin_use || !pinLvl[2];
  assign start = on && state_reg == SBCS_IDLE && (mst ? !txEmpty : selected);
  // target pops at its first leading edge: a deselect before any clock
  // leaves the word queued
  assign shPop = mst ? (start && !txEmpty) :
    (lead && bitCnt_reg == 4'h0 && txLoaded_reg);
  assign tick = halfCnt_reg == DIV_END;
  assign lead = state_reg == SBCS_SHIFT && (mst ?
    (tick && sckOut == cpolEff) : (cpolEff ? pinFell[0] : pinRose[0]));
  assign trail = state_reg == SBCS_SHIFT && (mst ?
    (tick && sckOut != cpolEff) : (cpolEff ? pinRose[0] : pinFell[0]));
  assign shPush = trail && bitCnt_reg == LAST_BIT;
  assign rxDrop = shPush && rxFull;
  // pin filter lag exceeds half a bit, so the controller takes the bit at
  // its own trailing edge; needs HALF_DIV of 3 or more
  assign rxBit = mst ? (!dissi && pinLvl[1]) : inBit_reg;

  always_comb begin
    case (ctrl_reg[SBCS_CTRL_STX +: 2])
      2'b11: txCond = !txFull;
      2'b10: txCond = enh ? (txCount < HALF) : txEmpty;
      2'b01: txCond = txEmpty;
      default: txCond = txEmpty && state_reg == SBCS_IDLE;
    endcase
    case (ctrl_reg[SBCS_CTRL_SRX +: 2])
      2'b11: rxCond = rxFull;
      2'b10: rxCond = enh ? (rxCount >= HALF) : rxFull;
      2'b01: rxCond = !rxEmpty;
      default: rxCond = 1'b0;
    endcase
  end

  assign txEvt = on && txCond && !txCondPrev;
  assign rxEvt = on && (ctrl_reg[SBCS_CTRL_SRX +: 2] == 2'b00 ?
    (swPop && (!enh || rxCount == ONE)) : (rxCond && !rxCondPrev));

  always_comb begin
    rdMux = 32'h0;
    case (address)
      SBCS_ADDR_CTRL: rdMux = ctrl_reg;
      SBCS_ADDR_STAT: begin
        rdMux[SBCS_STAT_BUSY] = state_reg == SBCS_SHIFT;
        rdMux[SBCS_STAT_TBE] = tbe_reg;
        rdMux[SBCS_STAT_TBF] = txFull;
        rdMux[SBCS_STAT_RBF] = rxFull;
      end
      SBCS_ADDR_BUF: rdMux[WORD_W-1:0] = rxEmpty ? '0 : rxMem[rxR_reg];
      SBCS_ADDR_IRQS: rdMux[SBCS_IRQ_W-1:0] = irqStat_reg;
      SBCS_ADDR_IRQM: rdMux[SBCS_IRQ_W-1:0] = irqMask_reg;
      default: rdMux = 32'h0;
    endcase
  end

  // bus slave: one wait cycle, then waitrequest low for exactly one cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0;
      popArm_reg <= 1'b0;
    end else if (ce) begin
      if ((read || write) && waitrequest) begin
        waitrequest <= 1'b0;
        readdata <= read ? rdMux : 32'h0;
        popArm_reg <= read && !rxEmpty;
      end else begin
        waitrequest <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg <= SBCS_CTRL_RST;
    end else if (ce && ctrlWr) begin
      if (on) begin
        ctrl_reg <= (ctrl_reg & SBCS_CTRL_LOCK) |
          (writedata & SBCS_CTRL_WMASK & ~SBCS_CTRL_LOCK);
      end else begin
        ctrl_reg <= writedata & SBCS_CTRL_WMASK;
      end
    end
  end

  // turning the unit off flushes both buffers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txW_reg <= '0;
      txR_reg <= '0;
    end else if (ce) begin
      if (!on) begin
        txW_reg <= '0;
        txR_reg <= '0;
      end else begin
        if (swPush) begin
          txMem[txW_reg] <= writedata[WORD_W-1:0];
          txW_reg <= txW_reg + ONE;
        end
        if (shPop) begin
          txR_reg <= txR_reg + ONE;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxW_reg <= '0;
      rxR_reg <= '0;
    end else if (ce) begin
      if (!on) begin
        rxW_reg <= '0;
        rxR_reg <= '0;
      end else begin
        if (shPush && !rxFull) begin
          rxMem[rxW_reg] <= {sr_reg[WORD_W-2:0], rxBit};
          rxW_reg <= rxW_reg + ONE;
        end
        if (swPop) begin
          rxR_reg <= rxR_reg + ONE;
        end
      end
    end
  end

  // hardware set wins over a same-cycle software clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tbe_reg <= 1'b1;
      rbf_reg <= 1'b0;
    end else if (ce) begin
      if (!on || shPop) begin
        tbe_reg <= 1'b1;
      end else if (swPush) begin
        tbe_reg <= 1'b0;
      end
      if (!on) begin
        rbf_reg <= 1'b0;
      end else if (shPush && !rxFull) begin
        rbf_reg <= 1'b1;
      end else if (swPop) begin
        rbf_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= SBCS_IDLE;
      sr_reg <= '0;
      bitCnt_reg <= 4'h0;
      halfCnt_reg <= 16'h0;
      inBit_reg <= 1'b0;
      txLoaded_reg <= 1'b0;
      sckOut <= 1'b0;
      sdoOut <= 1'b0;
    end else if (ce) begin
      case (state_reg)
        SBCS_IDLE: begin
          sckOut <= cpolEff;
          halfCnt_reg <= 16'h0;
          bitCnt_reg <= 4'h0;
          txLoaded_reg <= start && !txEmpty;
          if (start) begin
            state_reg <= SBCS_SHIFT;
            sr_reg <= !txEmpty ? txMem[txR_reg] : '0;
            sdoOut <= !txEmpty ? txMem[txR_reg][WORD_W-1] : 1'b0;
          end
        end
        SBCS_SHIFT: begin
          halfCnt_reg <= tick ? 16'h0 : halfCnt_reg + 16'h1;
          if (shPop) begin
            txLoaded_reg <= 1'b0;
          end
          if (mst && tick) begin
            sckOut <= !sckOut;
          end
          if (lead) begin
            inBit_reg <= dissi ? 1'b0 : pinLvl[1];
          end
          if (trail) begin
            sr_reg <= {sr_reg[WORD_W-2:0], rxBit};
            sdoOut <= sr_reg[WORD_W-2];
            bitCnt_reg <= bitCnt_reg + 4'h1;
          end
          if (!on || shPush || (!mst && !selected)) begin
            state_reg <= SBCS_IDLE;
          end
        end
        default: state_reg <= SBCS_IDLE;
      endcase
    end
  end

  assign irqSet = {rxDrop, rxEvt, txEvt};
  assign irqClr = (rdEn && address == SBCS_ADDR_IRQS) ?
    readdata[SBCS_IRQ_W-1:0] : '0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqStat_reg <= '0;
      irqMask_reg <= SBCS_IRQM_RST;
      txCondPrev <= 1'b0;
      rxCondPrev <= 1'b0;
      irq <= 1'b0;
      sckOe <= 1'b0;
      sdoOe <= 1'b0;
      selectPinUse <= 1'b0;
      serialInUsed <= 1'b0;
    end else if (ce) begin
      // only bits the reader actually saw are cleared
      irqStat_reg <= (irqStat_reg & ~irqClr) | irqSet;
      if (wrEn && address == SBCS_ADDR_IRQM) begin
        irqMask_reg <= writedata[SBCS_IRQ_W-1:0];
      end
      txCondPrev <= on && txCond;
      rxCondPrev <= on && rxCond;
      irq <= |(irqStat_reg & irqMask_reg);
      sckOe <= on && mst;
      sdoOe <= on && (mst || selected);
      selectPinUse <= on && !mst && select_pin_use;
      serialInUsed <= on && !dissi;
    end
  end

  property p_tbe_on_move;
    @(posedge clk) disable iff (!rst_n || !ce)
      (ce && shPop) |=> tbe_reg;
  endproperty
  a_tbe_on_move: assert property (p_tbe_on_move)
    else $error("tx empty flag not set after move to shifter");

  property p_tbf_enh;
    @(posedge clk) disable iff (!rst_n || !ce)
      (on && enh) |-> (txFull == (txCount == TOP));
  endproperty
  a_tbf_enh: assert property (p_tbf_enh)
    else $error("enhanced tx full disagrees with pointer distance");

  property p_tbf_std;
    @(posedge clk) disable iff (!rst_n || !ce)
      (on && !enh && swPush && !ctrlWr) |=>
        txFull until_with (shPop || !on);
  endproperty
  a_tbf_std: assert property (p_tbf_std)
    else $error("standard tx full dropped before move to shifter");

  property p_rbf_std;
    @(posedge clk) disable iff (!rst_n || !ce)
      (on && !enh && shPush && !rxFull && !ctrlWr) |=> rxFull;
  endproperty
  a_rbf_std: assert property (p_rbf_std)
    else $error("standard rx full not set after receive");

  property p_rbf_enh;
    @(posedge clk) disable iff (!rst_n || !ce)
      (on && enh) |-> (rxFull == (rxCount == TOP));
  endproperty
  a_rbf_enh: assert property (p_rbf_enh)
    else $error("enhanced rx full disagrees with pointer distance");

  property p_idle_level;
    @(posedge clk) disable iff (!rst_n || !ce)
      (state_reg == SBCS_IDLE && !start && !ctrlWr)[*2] |->
        sckOut == cpolEff;
  endproperty
  a_idle_level: assert property (p_idle_level)
    else $error("serial clock not at its idle level");

  property p_lock;
    @(posedge clk) disable iff (!rst_n || !ce)
      (ctrlWr && on) |=>
        (ctrl_reg & SBCS_CTRL_LOCK) == ($past(ctrl_reg) & SBCS_CTRL_LOCK);
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked control bit changed while unit on");

  property p_ptr_step;
    @(posedge clk) disable iff (!rst_n || !ce)
      (on && swPush && !ctrlWr) |=> txW_reg == $past(txW_reg) + ONE;
  endproperty
  a_ptr_step: assert property (p_ptr_step)
    else $error("tx write pointer did not advance by one");

  property p_release;
    @(posedge clk) disable iff (!rst_n || !ce)
      (lead && dissi) |=> !inBit_reg;
  endproperty
  a_release: assert property (p_release)
    else $error("serial input sampled while released");

  property p_target_abort;
    @(posedge clk) disable iff (!rst_n || !ce)
      (state_reg == SBCS_SHIFT && !mst && select_pin_use && pinLvl[2]) |=>
        state_reg == SBCS_IDLE;
  endproperty
  a_target_abort: assert property (p_target_abort)
    else $error("target kept shifting after deselect");

  property p_role;
    @(posedge clk) disable iff (!rst_n || !ce)
      (on && !mst && !ctrlWr)[*2] |-> !sckOe;
  endproperty
  a_role: assert property (p_role)
    else $error("clock driven while in target role");

  property p_tx_irq;
    @(posedge clk) disable iff (!rst_n || !ce)
      txEvt |=> irqStat_reg[SBCS_IRQ_TX] ##1 (irq || !irqMask_reg[0]);
  endproperty
  a_tx_irq: assert property (p_tx_irq)
    else $error("tx condition did not raise the interrupt");
endmodule

// [hw/sbcs_sync.sv]
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module sbcs_sync #(
  parameter logic RST_LVL = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic din,
  output logic level,
  output logic rose,
  output logic fell
);
  logic [2:0] stage;
  logic agree;

  assign agree = stage[1] == stage[2];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // start at the pin's idle level so no false edge follows reset
      stage <= {3{RST_LVL}};
      level <= RST_LVL;
      rose <= 1'b0;
      fell <= 1'b0;
    end else if (ce) begin
      stage <= {stage[1:0], din};
      if (agree) begin
        level <= stage[2];
      end
      rose <= agree && stage[2] && !level;
      fell <= agree && !stage[2] && level;
    end
  end

  property p_level_follows;
    @(posedge clk) disable iff (!rst_n || !ce)
      (ce && agree && stage[2] != level) |=> (level == $past(stage[2]));
  endproperty
  a_level_follows: assert property (p_level_follows)
    else $error("synchronised level missed an agreed change");
endmodule

// [include/sbcs_pkg.sv]
// constants and types for the serial port buffer, control and status block
// Overview of operation
// - target role with select use set frames on select pin; else pin is ignored
// - clock idle polarity bit picks idle level: set idles high, clear low
// - audio mode forces behaviour as if clock idle polarity were set
// - role bit set makes the unit controller, clear makes it target
// - serial-input release set ignores serial input pin unless framed; clear uses it
// - tx irq: 11 not full, 10 half empty, 01 empty, 00 shift done
// - rx irq: 11 full, 10 half full, 01 not empty, 00 last word read
// - tx empty flag sets on move to shifter, clears on buffer write
// - standard mode tx full sets on buffer write, clears on move out
// - enhanced mode tx full is high exactly when write pointer+1 equals read
// - standard mode rx full sets on shifter move in, clears on read
// - enhanced mode rx full high exactly when shift write ptr+1 equals read
package sbcs_pkg;
  localparam logic [4:0] SBCS_ADDR_CTRL = 5'h00;
  localparam logic [4:0] SBCS_ADDR_STAT = 5'h04;
  localparam logic [4:0] SBCS_ADDR_BUF = 5'h08;
  localparam logic [4:0] SBCS_ADDR_IRQS = 5'h0c;
  localparam logic [4:0] SBCS_ADDR_IRQM = 5'h10;
  localparam int SBCS_CTRL_SRX = 0;
  localparam int SBCS_CTRL_STX = 2;
  localparam int SBCS_CTRL_DISSI = 4;
  localparam int SBCS_CTRL_MST = 5;
  localparam int SBCS_CTRL_CKP = 6;
  localparam int SBCS_CTRL_SELECT_PIN_USE = 7;
  localparam int SBCS_CTRL_ON = 15;
  localparam int SBCS_CTRL_ENH = 16;
  localparam int SBCS_CTRL_AUD = 17;
  localparam int SBCS_CTRL_FRM = 18;
  localparam logic [31:0] SBCS_CTRL_WMASK = 32'h0007_80ff;
  localparam logic [31:0] SBCS_CTRL_LOCK = 32'h0007_00f0;
  localparam logic [31:0] SBCS_CTRL_RST = 32'h0000_0000;
  localparam int SBCS_STAT_RBF = 0;
  localparam int SBCS_STAT_TBF = 1;
  localparam int SBCS_STAT_TBE = 3;
  localparam int SBCS_STAT_BUSY = 11;
  localparam int SBCS_IRQ_TX = 0;
  localparam int SBCS_IRQ_RX = 1;
  localparam int SBCS_IRQ_OVF = 2;
  localparam int SBCS_IRQ_W = 3;
  localparam logic [2:0] SBCS_IRQM_RST = 3'h0;
  localparam int SBCS_WORD_W = 8;
  localparam int SBCS_DEPTH = 4;
  localparam int SBCS_HALF_DIV = 4;
  typedef enum logic [0:0] {
    SBCS_IDLE = 1'b0,
    SBCS_SHIFT = 1'b1
  } sbcs_state_e;
endpackage

// [verif/sbcs_peer.sv]
// link-side model of the serial device facing the unit
`timescale 1ns/1ps
module sbcs_peer (
  input wire logic sck,
  input wire logic leads,
  input wire logic pol,
  input wire logic sdo,
  output logic sckDrv,
  output logic sdi,
  output logic selN
);
  logic [7:0] txW;
  logic [7:0] rxW;
  initial begin
    sckDrv = 1'b0;
    selN = 1'b1;
    txW = 8'h00;
    rxW = 8'h00;
    sdi = 1'b0;
  end
  task automatic load(input logic [7:0] d);
    txW = d;
    sdi = d[7];
  endtask
  // target role: sample on leading edge, next bit on trailing edge
  always @(sck) begin
    if (leads) begin
      if (sck !== pol) begin
        rxW = {rxW[6:0], sdo};
      end else begin
        txW = txW << 1;
        sdi = txW[7];
      end
    end
  end
  // controller role, 160 ns period; bits move late for the pin filter
  task automatic xfer(input logic [7:0] d, output logic [7:0] r);
    #7;
    selN = 1'b0;
    load(d);
    #160;
    repeat (8) begin
      sckDrv = ~pol;
      #70;
      rxW = {rxW[6:0], sdo};
      #10;
      sckDrv = pol;
      #40;
      txW = txW << 1;
      sdi = txW[7];
      #40;
    end
    #160;
    selN = 1'b1;
    // released line shows the inverse rather than a stale bit
    sdi = ~sdi;
    r = rxW;
  endtask
endmodule

// [verif/sbcs_test.sv]
// register-level bench for the serial port unit and its link
`timescale 1ns/1ps
module sbcs_test;
  import sbcs_pkg::*;
  localparam logic [31:0] ON = 32'h1 << SBCS_CTRL_ON;
  localparam logic [31:0] MST = 32'h1 << SBCS_CTRL_MST;
  localparam logic [31:0] CLOCK_IDLE_POLARITY = 32'h1 << SBCS_CTRL_CKP;
  localparam logic [31:0] AUD = 32'h1 << SBCS_CTRL_AUD;
  localparam logic [31:0] SELECT_PIN_USE = 32'h1 << SBCS_CTRL_SELECT_PIN_USE;
  localparam logic [31:0] DIS = 32'h1 << SBCS_CTRL_DISSI;
  localparam logic [31:0] ENH = 32'h1 << SBCS_CTRL_ENH;
  logic clk = 1'b0;
  logic rstN = 1'b0;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest, sckOut, sckOe, sdoOut, sdoOe, irq;
  logic selectPinUse, serialInUsed, sckDrv, sdi, selN, sckLine;
  int num_errors = 0;
  int cmp_count = 0;
  logic [31:0] q;
  logic [7:0] r;
  always #10 clk = ~clk;
  assign sckLine = sckOe ? sckOut : sckDrv;
  sbcs_core i_sbcs_core (.clk(clk), .rst_n(rstN), .ce(1'b1),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .sckIn(sckLine), .sckOut(sckOut),
    .sckOe(sckOe), .serialInPin(sdi), .sdoOut(sdoOut), .sdoOe(sdoOe),
    .targetSelectPinN(selN), .irq(irq), .selectPinUse(selectPinUse),
    .serialInUsed(serialInUsed));
  sbcs_peer i_sbcs_peer (.sck(sckLine), .leads(sckOe), .pol(1'b0),
    .sdo(sdoOut), .sckDrv(sckDrv), .sdi(sdi), .selN(selN));
  task automatic final_report();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    write <= wr;
    read <= ~wr;
    writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      final_report();
    end
  endtask
  task automatic rc(input logic [4:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  // locked bits change only with the unit off
  task automatic setCtrl(input logic [31:0] v);
    wr(SBCS_ADDR_CTRL, 32'h0);
    wr(SBCS_ADDR_CTRL, v);
    repeat (3) @(posedge clk);
  endtask
  task automatic waitRx();
    int n;
    n = 0;
    do begin
      bus(1'b0, SBCS_ADDR_STAT, 32'h0);
      n++;
    end while (q[SBCS_STAT_RBF] !== 1'b1 && n < 100);
    if (n >= 100) begin
      num_errors++;
      final_report();
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rstN <= 1'b1;
    rc(SBCS_ADDR_CTRL, 32'hffffffff, 32'h0);
    rc(SBCS_ADDR_STAT, 32'hb, 32'h8);
    rc(SBCS_ADDR_IRQM, 32'hffffffff, 32'h0);
    wr(5'h14, 32'hff);
    rc(5'h14, 32'hffffffff, 32'h0);
    setCtrl(ON | MST);
    chk({30'h0, sckOe, sckOut}, 32'h2);
    i_sbcs_peer.load(8'h3c);
    wr(SBCS_ADDR_BUF, 32'ha5);
    waitRx();
    chk({24'h0, i_sbcs_peer.rxW}, 32'ha5);
    rc(SBCS_ADDR_STAT, 32'hb, 32'h9);
    chk({31'h0, irq}, 32'h0);
    rc(SBCS_ADDR_BUF, 32'hff, 32'h3c);
    rc(SBCS_ADDR_STAT, 32'h1, 32'h0);
    wr(SBCS_ADDR_CTRL, ON | MST | CLOCK_IDLE_POLARITY);
    rc(SBCS_ADDR_CTRL, 32'hffffffff, ON | MST);
    setCtrl(ON | MST | CLOCK_IDLE_POLARITY);
    chk({30'h0, sckOe, sckOut}, 32'h3);
    setCtrl(ON | MST | AUD);
    chk({30'h0, sckOe, sckOut}, 32'h3);
    setCtrl(ON | SELECT_PIN_USE);
    chk({28'h0, sdoOe, sckOe, selectPinUse, serialInUsed},
      32'h3);
    setCtrl(ON | SELECT_PIN_USE | MST);
    chk({28'h0, sdoOe, sckOe, selectPinUse, serialInUsed},
      32'hd);
    setCtrl(ON | DIS);
    chk({28'h0, sdoOe, sckOe, selectPinUse, serialInUsed},
      32'h8);
    // released input: ones on the pin must arrive as zeros
    i_sbcs_peer.xfer(8'hff, r);
    rc(SBCS_ADDR_STAT, 32'h1, 32'h1);
    rc(SBCS_ADDR_BUF, 32'hff, 32'h0);
    for (int c = 0; c < 4; c++) begin
      setCtrl(ON | MST | (32'(c) << 2) | 32'(c));
      wr(SBCS_ADDR_IRQM, 32'h3);
      rc(SBCS_ADDR_IRQS, 32'h1, 32'h1);
      i_sbcs_peer.load(8'h40 + 8'(c));
      wr(SBCS_ADDR_BUF, 32'h5a);
      waitRx();
      chk({31'h0, irq}, 32'h1);
      rc(SBCS_ADDR_IRQS, 32'h3, {30'h0, c != 0, 1'b1});
      rc(SBCS_ADDR_BUF, 32'hff, 32'h40 + 32'(c));
      rc(SBCS_ADDR_IRQS, 32'h3, {30'h0, c == 0, 1'b0});
    end
    // target role: no clock until selected, so the buffers fill
    setCtrl(ON | SELECT_PIN_USE | ENH);
    for (int k = 0; k < 5; k++) wr(SBCS_ADDR_BUF, 32'(k + 1));
    rc(SBCS_ADDR_STAT, 32'ha, 32'h2);
    for (int k = 0; k < 6; k++) begin
      i_sbcs_peer.xfer(8'h10 + 8'(k), r);
      if (k < 3) chk({24'h0, r}, 32'(k + 1));
      if (k == 5) chk({24'h0, r}, 32'h0);
    end
    rc(SBCS_ADDR_STAT, 32'hb, 32'h9);
    rc(SBCS_ADDR_IRQS, 32'h4, 32'h4);
    for (int k = 0; k < 3; k++) begin
      rc(SBCS_ADDR_BUF, 32'hff, 32'h10 + 32'(k));
    end
    rc(SBCS_ADDR_STAT, 32'h1, 32'h0);
    final_report();
  end
endmodule
